// file: pkg/wdt_pkg.sv
package wdt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] WDT_CTRL_OFFSET = 8'h60;
    localparam logic [ADDR_W-1:0] RST_STATUS_OFFSET = 8'h64;

    ////////////////////////////////////////////////////////////////////////
    // watchdog_control fields
    localparam int CE_BIT = 4;
    localparam int EN_BIT = 3;
    localparam int PSEL_LSB = 0;
    localparam int PSEL_W = 3;
    localparam int CTRL_RSVD_W = 3;
    localparam logic [DATA_W-1:0] CTRL_RESET_VALUE = 8'h00;
    localparam logic [PSEL_W-1:0] PSEL_RESET_VALUE = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // reset_cause_status fields
    localparam int FLAG_W = 5;
    localparam int TEST_PORT_FLAG_BIT = 4;
    localparam int WATCHDOG_FLAG_BIT = 3;
    localparam int BROWNOUT_FLAG_BIT = 2;
    localparam int EXTERNAL_FLAG_BIT = 1;
    localparam int POWER_ON_FLAG_BIT = 0;
    localparam int STATUS_RSVD_W = DATA_W - FLAG_W;
    localparam logic [FLAG_W-1:0] FLAGS_POWER_ON_VALUE = 5'h01;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CE_WINDOW_W = 3;
    localparam logic [CE_WINDOW_W-1:0] CE_WINDOW_CYCLES = 3'h4;
    localparam int TIMEOUT_BASE_CYCLES = 16384;
    localparam int CNT_W = 21;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic test_port;
        logic brownout;
        logic external_pin;
    } reset_src_s;

endpackage

// file: verilog/wdt_tick_sync.sv
`timescale 1ns/100ps

// brings the watchdog oscillator into the core domain and marks each rising edge
module wdt_tick_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // oscillator level
    input wire logic osc_in,
    // one-cycle pulse per oscillator rising edge
    output logic tick
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= osc_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign tick = sync_q & ~prev_q;

endmodule

// file: verilog/watchdog_and_reset_flags.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps

// How it works
// - test-port reset sets flag; power-on or zero clears
// - watchdog reset sets flag; power-on or zero clears
// - brown-out reset sets flag; power-on or zero clears
// - external reset sets flag; power-on or zero clears
// - power-on sets flag; only writing zero clears
// - control bits seven to five read zero
// - change-enable self-clears four cycles after set
// - enable clears only while change-enable is one
// - prescaler changes only inside change-enable window
// - writing enable one always enables watchdog
// - higher safety level keeps watchdog always enabled
// - timeout is 16K times two to select
// - expiry without restart resets the chip
// - restart, disable or chip reset clear counter
// - timeout gives a one-cycle reset pulse
// - higher safety level reads enable as one
module watchdog_and_reset_flags (
    // clock and power-on reset
    input wire logic core_clk,
    input wire logic rstn,
    // chip reset held by any source, clears the watchdog
    input wire logic chip_reset,
    // register port
    input wire wdt_pkg::reg_req_s reg_req,
    output logic [wdt_pkg::DATA_W-1:0] reg_rdata,
    // configuration and processor
    input wire logic safety_level_fuse,
    input wire logic watchdog_restart_instruction,
    // watchdog oscillator level
    input wire logic wdt_osc_clk,
    // reset sources other than power-on and watchdog
    input wire wdt_pkg::reset_src_s reset_src,
    // watchdog results
    output logic wdt_reset_pulse,
    output logic wdt_enabled
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic wr_ctrl;
    logic wr_status;
    logic rd_ctrl;
    logic rd_status;

    logic wdata_ce;
    logic wdata_en;
    logic [wdt_pkg::PSEL_W-1:0] wdata_psel;
    logic open_request;

    logic [wdt_pkg::CE_WINDOW_W-1:0] window_q;
    logic window_open;

    logic en_q;
    logic [wdt_pkg::PSEL_W-1:0] psel_q;
    logic en_effective;

    logic osc_tick;
    logic [wdt_pkg::CNT_W-1:0] count_q;
    logic [wdt_pkg::CNT_W:0] limit_full;
    logic [wdt_pkg::CNT_W-1:0] terminal;
    logic expire;
    logic pulse_q;

    logic [wdt_pkg::FLAG_W-1:0] flags_q;
    logic [wdt_pkg::FLAG_W-1:0] flags_set;
    logic [wdt_pkg::FLAG_W-1:0] flags_keep;

    logic [wdt_pkg::DATA_W-1:0] ctrl_view;
    logic [wdt_pkg::DATA_W-1:0] status_view;
    logic [wdt_pkg::DATA_W-1:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    assign wr_ctrl = reg_req.wr && (reg_req.addr == wdt_pkg::WDT_CTRL_OFFSET);
    assign wr_status = reg_req.wr && (reg_req.addr == wdt_pkg::RST_STATUS_OFFSET);
    assign rd_ctrl = reg_req.rd && (reg_req.addr == wdt_pkg::WDT_CTRL_OFFSET);
    assign rd_status = reg_req.rd && (reg_req.addr == wdt_pkg::RST_STATUS_OFFSET);

    assign wdata_ce = reg_req.wdata[wdt_pkg::CE_BIT];
    assign wdata_en = reg_req.wdata[wdt_pkg::EN_BIT];
    assign wdata_psel = reg_req.wdata[wdt_pkg::PSEL_LSB +: wdt_pkg::PSEL_W];

    // both ones in one write start the timed sequence, whatever enable held
    assign open_request = wr_ctrl && wdata_ce && wdata_en;

    ////////////////////////////////////////////////////////////////////////
    // change-enable window

    assign window_open = (window_q != '0);

    // a repeated opening write reloads the full window
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            window_q <= '0;
        end else if (chip_reset) begin
            window_q <= '0;
        end else if (open_request) begin
            window_q <= wdt_pkg::CE_WINDOW_CYCLES;
        end else if (wr_ctrl && window_open) begin
            // the second step of the sequence ends the window at once
            window_q <= '0;
        end else if (window_open) begin
            window_q <= window_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable bit

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            en_q <= wdt_pkg::CTRL_RESET_VALUE[wdt_pkg::EN_BIT];
        end else if (chip_reset) begin
            en_q <= wdt_pkg::CTRL_RESET_VALUE[wdt_pkg::EN_BIT];
        end else if (open_request) begin
            // enable was written one, so it stays or becomes one
            en_q <= 1'b1;
        end else if (wr_ctrl && wdata_en) begin
            en_q <= 1'b1;
        end else if (wr_ctrl && window_open) begin
            en_q <= 1'b0;
        end
    end

    // the fuse overrides any disable sequence
    assign en_effective = en_q | safety_level_fuse;

    ////////////////////////////////////////////////////////////////////////
    // prescaler select

    // changes outside the window are dropped silently
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            psel_q <= wdt_pkg::PSEL_RESET_VALUE;
        end else if (chip_reset) begin
            psel_q <= wdt_pkg::PSEL_RESET_VALUE;
        end else if (wr_ctrl && window_open && !open_request) begin
            psel_q <= wdata_psel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator crossing

    // the oscillator is far slower than the core clock, so each of its
    // rising edges shows as one tick after a two-stage synchroniser
    wdt_tick_sync u_tick_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .osc_in(wdt_osc_clk),
        .tick(osc_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // timeout counter

    assign limit_full = (wdt_pkg::CNT_W + 1)'(wdt_pkg::TIMEOUT_BASE_CYCLES) << psel_q;
    assign terminal = wdt_pkg::CNT_W'(limit_full - 1'b1);

    // greater-or-equal: a shorter period chosen mid-count expires on the next tick
    assign expire = en_effective && osc_tick && (count_q >= terminal);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (chip_reset || !en_effective || watchdog_restart_instruction) begin
            count_q <= '0;
        end else if (expire) begin
            count_q <= '0;
        end else if (osc_tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    // the reset generator starts its delay on the falling edge of this pulse
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= expire;
        end
    end

    assign wdt_reset_pulse = pulse_q;
    assign wdt_enabled = en_effective;

    ////////////////////////////////////////////////////////////////////////
    // reset cause flags

    always_comb begin
        flags_set = '0;
        flags_set[wdt_pkg::TEST_PORT_FLAG_BIT] = reset_src.test_port;
        flags_set[wdt_pkg::WATCHDOG_FLAG_BIT] = pulse_q;
        flags_set[wdt_pkg::BROWNOUT_FLAG_BIT] = reset_src.brownout;
        flags_set[wdt_pkg::EXTERNAL_FLAG_BIT] = reset_src.external_pin;
    end

    // a written zero clears a flag, a written one leaves it alone
    assign flags_keep = wr_status ? reg_req.wdata[wdt_pkg::FLAG_W-1:0] : '1;

    // these flags ignore chip_reset, so the cause survives the reset it made;
    // a set in the same cycle as a clear wins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            flags_q <= wdt_pkg::FLAGS_POWER_ON_VALUE;
        end else begin
            flags_q <= (flags_q & flags_keep) | flags_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        ctrl_view = '0;
        ctrl_view[wdt_pkg::CE_BIT] = window_open;
        ctrl_view[wdt_pkg::EN_BIT] = en_effective;
        ctrl_view[wdt_pkg::PSEL_LSB +: wdt_pkg::PSEL_W] = psel_q;
    end

    assign status_view = {{wdt_pkg::STATUS_RSVD_W{1'b0}}, flags_q};

    // read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else if (rd_ctrl) begin
            rdata_q <= ctrl_view;
        end else if (rd_status) begin
            rdata_q <= status_view;
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

// file: tb/wdt_flags_asserts.sv
`timescale 1ns/100ps
module wdt_flags_checker (
    // clock and power-on reset
    input wire logic core_clk,
    input wire logic rstn,
    // stimulus side
    input wire logic chip_reset,
    input wire wdt_pkg::reg_req_s reg_req,
    input wire logic safety_level_fuse,
    input wire logic watchdog_restart_instruction,
    input wire logic wdt_osc_clk,
    input wire wdt_pkg::reset_src_s reset_src,
    // results
    input wire logic [wdt_pkg::DATA_W-1:0] reg_rdata,
    input wire logic wdt_reset_pulse,
    input wire logic wdt_enabled
);
    logic ctl_wr;
    logic ctl_rd;
    logic st_rd;
    logic [2:0] win_q;
    assign ctl_wr = reg_req.wr && reg_req.addr == wdt_pkg::WDT_CTRL_OFFSET;
    assign ctl_rd = reg_req.rd && reg_req.addr == wdt_pkg::WDT_CTRL_OFFSET;
    assign st_rd = reg_req.rd && reg_req.addr == wdt_pkg::RST_STATUS_OFFSET;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    // shadow of the change window, since the window itself is not a port
    always_ff @(posedge core_clk) begin
        if (!rstn || chip_reset) begin
            win_q <= 3'h0;
        end else if (ctl_wr) begin
            win_q <= (reg_req.wdata[4] && reg_req.wdata[3]) ? 3'h4 : 3'h0;
        end else if (win_q != 3'h0) begin
            win_q <= win_q - 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_ctrl_rsvd_zero: assert property (ctl_rd |=> reg_rdata[7:5] == 3'h0)
        else $error("reserved bits read nonzero");
    a_ce_readback: assert property (ctl_rd |=> reg_rdata[4] == $past(win_q != 3'h0))
        else $error("change enable readback wrong");
    a_en_guard: assert property (ctl_wr && !reg_req.wdata[3] && win_q == 3'h0 && wdt_enabled
        && !chip_reset && !safety_level_fuse |=> wdt_enabled) else $error("disabled outside window");
    a_write_enables: assert property (ctl_wr && reg_req.wdata[3] && !chip_reset |=> wdt_enabled)
        else $error("enable write ignored");
    a_fuse_forces_en: assert property (safety_level_fuse |-> wdt_enabled)
        else $error("fuse did not force enable");
    a_fuse_reads_en: assert property (ctl_rd && safety_level_fuse |=> reg_rdata[3])
        else $error("enable bit read zero under fuse");
    a_pulse_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
        else $error("reset pulse longer than one cycle");
    a_wdog_flag: assert property (st_rd && $past(wdt_reset_pulse) |=> reg_rdata[3])
        else $error("watchdog flag not set");
    a_ext_flag: assert property (st_rd && $past(reset_src.external_pin) |=> reg_rdata[1])
        else $error("external flag not set");
endmodule
////////////////////////////////////////////////////////////////////////////
bind watchdog_and_reset_flags wdt_flags_checker u_chk (
    .core_clk(core_clk), .rstn(rstn), .chip_reset(chip_reset), .reg_req(reg_req),
    .safety_level_fuse(safety_level_fuse),
    .watchdog_restart_instruction(watchdog_restart_instruction),
    .wdt_osc_clk(wdt_osc_clk), .reset_src(reset_src), .reg_rdata(reg_rdata),
    .wdt_reset_pulse(wdt_reset_pulse), .wdt_enabled(wdt_enabled)
);

// file: tb/watchdog_and_reset_flags_tb_top.sv
`timescale 1ns/100ps
module watchdog_and_reset_flags_tb_top;
    localparam logic [7:0] CT = wdt_pkg::WDT_CTRL_OFFSET;
    localparam logic [7:0] ST = wdt_pkg::RST_STATUS_OFFSET;
    // oscillator period is six core cycles, three core cycles at each level
    localparam int TMO = wdt_pkg::TIMEOUT_BASE_CYCLES * 6;
    logic core_clk = 0;
    logic rstn = 0;
    logic chip_reset = 0;
    logic safety_level_fuse = 0;
    logic watchdog_restart_instruction = 0;
    logic wdt_osc_clk = 0;
    wdt_pkg::reg_req_s reg_req = '0;
    wdt_pkg::reset_src_s reset_src = '0;
    logic [7:0] reg_rdata;
    logic wdt_reset_pulse;
    logic wdt_enabled;
    logic [2:0] ph = 3'h0;
    logic [4:0] st;
    logic [7:0] ctl;
    logic [7:0] d;
    int n_mismatch = 0;
    int checks_done = 0;
    int n;
    int g;

    watchdog_and_reset_flags dut (
        .core_clk(core_clk), .rstn(rstn), .chip_reset(chip_reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .safety_level_fuse(safety_level_fuse),
        .watchdog_restart_instruction(watchdog_restart_instruction),
        .wdt_osc_clk(wdt_osc_clk), .reset_src(reset_src),
        .wdt_reset_pulse(wdt_reset_pulse), .wdt_enabled(wdt_enabled)
    );

    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        ph <= (ph == 3'h2) ? 3'h0 : ph + 3'h1;
        wdt_osc_clk <= (ph == 3'h2) ? ~wdt_osc_clk : wdt_osc_clk;
    end
    initial begin
        // the timeout test alone needs about 98,500 cycles
        repeat (100000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////
    task end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] dd);
        @(posedge core_clk);
        reg_req <= '{a, dd, w, r};
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        put(1'b0, 1'b1, a, 8'h00);
        put(1'b0, 1'b0, a, 8'h00);
        #1;
        chk(reg_rdata, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h1117B627));
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        st = 5'h01;
        ctl = 8'h00;
        rd(ST, {3'h0, st});
        rd(CT, ctl);
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            reset_src <= 3'(1 << i);
            st = st | ((i == 2) ? 5'h10 : 5'h02 << i);
            rd(ST, {3'h0, st});
            @(posedge core_clk);
            reset_src <= '0;
        end
        for (int j = 0; j < 3; j++) begin
            d = 8'($urandom);
            put(1'b1, 1'b0, ST, d);
            st = st & d[4:0];
            rd(ST, {3'h0, st});
        end
        @(posedge core_clk);
        chip_reset <= 1'b1;
        @(posedge core_clk);
        chip_reset <= 1'b0;
        rd(ST, {3'h0, st});
        $display("test flags done");
        put(1'b1, 1'b0, CT, 8'h08);
        put(1'b1, 1'b0, CT, 8'h05);
        ctl = 8'h08;
        rd(CT, ctl);
        put(1'b1, 1'b0, CT, 8'h18);
        rd(CT, 8'h18);
        for (int k = 0; k < 10; k++) begin
            d = 8'($urandom);
            g = k % 5;
            put(1'b1, 1'b0, CT, 8'h18);
            ctl = ctl | 8'h08;
            repeat (g) put(1'b0, 1'b0, CT, 8'h00);
            put(1'b1, 1'b0, CT, {d[7:5], 1'b0, d[3], 3'(k)});
            if (g < 4) ctl = {4'h0, d[3], 3'(k)};
            rd(CT, ctl);
            chk({7'h0, wdt_enabled}, {7'h0, ctl[3]});
        end
        $display("test window done");
        @(posedge core_clk);
        safety_level_fuse <= 1'b1;
        put(1'b1, 1'b0, CT, 8'h18);
        put(1'b1, 1'b0, CT, 8'h00);
        rd(CT, 8'h08);
        chk({7'h0, wdt_enabled}, 8'h01);
        @(posedge core_clk);
        watchdog_restart_instruction <= 1'b1;
        safety_level_fuse <= 1'b0;
        chip_reset <= 1'b1;
        @(posedge core_clk);
        watchdog_restart_instruction <= 1'b0;
        chip_reset <= 1'b0;
        rd(CT, 8'h00);
        $display("test fuse done");
        put(1'b1, 1'b0, CT, 8'h08);
        put(1'b0, 1'b0, CT, 8'h00);
        // a restart partway through must push the expiry out by a whole period
        repeat (120) @(posedge core_clk);
        watchdog_restart_instruction <= 1'b1;
        @(posedge core_clk);
        watchdog_restart_instruction <= 1'b0;
        n = 0;
        while (wdt_reset_pulse !== 1'b1 && n < TMO + 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(8'(n > TMO - 16 && n < TMO + 16), 8'h01);
        rd(ST, {3'h0, st | 5'h08});
        $display("test timeout done");
        end_sim();
    end
endmodule
